// File: spd_params.svh
// Purpose: constants for shared bidirectional port d
// Assumes: axi4-lite byte addresses, one 32-bit word per register
// Notes:   offsets, field positions, widths, reset values and response codes only
`ifndef SPD_PARAMS_SVH
`define SPD_PARAMS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define SPD_OFF_PIN_LEVELS   8'h00
`define SPD_OFF_DIRECTION    8'h04
`define SPD_OFF_OUT_LATCH    8'h08
`define SPD_OFF_MEM_CTRL     8'h0c
`define SPD_OFF_PAR_CTRL     8'h10
`define SPD_OFF_PORTA_LATCH  8'h14
`define SPD_OFF_STATUS       8'h18

// ****************************************
// field positions
// ****************************************
`define SPD_BIT_EXT_BUS_DIS  7
`define SPD_BIT_PAR_MODE     4
`define SPD_BIT_PULLUP_EN    7
`define SPD_BIT_STAT_LARGE   8

// ****************************************
// widths, masks, reset values and response codes
// ****************************************
`define SPD_W_LARGE          8
`define SPD_W_SMALL          3
`define SPD_MASK_SMALL       8'h07
`define SPD_MASK_LARGE       8'hff
`define SPD_RST_DIRECTION    8'hff
`define SPD_RST_OUT_LATCH    8'h00
`define SPD_RST_MEM_CTRL     8'h80
`define SPD_RST_PAR_CTRL     8'h00
`define SPD_RST_PORTA_LATCH  8'h00
`define SPD_RESP_OKAY        2'b00
`define SPD_RESP_SLVERR      2'b10

`endif

// File: spd_pkg.sv
// Purpose: types for shared bidirectional port d
// Assumes: spd_params.svh holds every number
// Notes:   driver source order after SPD_SRC_NONE is the pin priority order
package spd_pkg;

  typedef logic [7:0] spd_byte_t;

  typedef enum logic [2:0] {
    SPD_SRC_NONE,
    SPD_SRC_EMI,
    SPD_SRC_PSP,
    SPD_SRC_PWM,
    SPD_SRC_LATCH
  } spd_src_t;

endpackage

// File: spd_mux_if.sv
// Purpose: carrier between port d register block and pin selector
// Assumes: one clock domain, purely combinational selector
// Notes:   no clocking block
`timescale 1ns/10ps
interface spd_mux_if;
  import spd_pkg::*;

  spd_byte_t direction;
  spd_byte_t out_latch;
  spd_byte_t width_mask;
  logic      emi_active;
  logic      emi_drive;
  spd_byte_t emi_addr_data;
  logic      psp_active;
  logic      psp_read;
  logic      pwm_route;
  logic      pwm_level;
  logic      pwm_tristate;
  logic      pullup_req;
  spd_byte_t next_pin_out;
  spd_byte_t next_pin_oe;
  spd_byte_t next_pin_pullup;

  modport regs (
    output direction, out_latch, width_mask, emi_active, emi_drive, emi_addr_data,
    output psp_active, psp_read, pwm_route, pwm_level, pwm_tristate, pullup_req,
    input  next_pin_out, next_pin_oe, next_pin_pullup
  );
  modport sel (
    input  direction, out_latch, width_mask, emi_active, emi_drive, emi_addr_data,
    input  psp_active, psp_read, pwm_route, pwm_level, pwm_tristate, pullup_req,
    output next_pin_out, next_pin_oe, next_pin_pullup
  );
endinterface

// File: spd_pin_mux.sv
// Purpose: per-pin driver selection for port d
// Assumes: controls already qualified by package size and bus disable
// Notes:   pwm channel b is wired to pin 0 only
`timescale 1ns/10ps
module spd_pin_mux
  import spd_pkg::*;
(
  spd_mux_if.sel m // controls in, pin drive out
);

  // ****************************************
  // driver source per pin
  // ****************************************
  function automatic spd_src_t spd_pick(input logic is_pin0, input logic dir_bit);
    if (m.emi_active) begin
      spd_pick = SPD_SRC_EMI;
    end else if (m.psp_active) begin
      spd_pick = SPD_SRC_PSP;
    end else if (is_pin0 && m.pwm_route) begin
      spd_pick = SPD_SRC_PWM;
    end else if (!dir_bit) begin
      spd_pick = SPD_SRC_LATCH;
    end else begin
      spd_pick = SPD_SRC_NONE;
    end
  endfunction

  always_comb begin
    spd_src_t s;
    s = SPD_SRC_NONE;
    m.next_pin_out    = 8'h00;
    m.next_pin_oe     = 8'h00;
    m.next_pin_pullup = 8'h00;
    for (int i = 0; i < 8; i++) begin
      s = spd_pick(i == 0, m.direction[i]);
      unique case (s)
        SPD_SRC_EMI: begin
          m.next_pin_out[i] = m.emi_addr_data[i];
          m.next_pin_oe[i]  = m.emi_drive;
        end
        SPD_SRC_PSP: begin
          m.next_pin_out[i] = m.out_latch[i];
          m.next_pin_oe[i]  = m.psp_read;
        end
        SPD_SRC_PWM: begin
          m.next_pin_out[i] = m.pwm_level;
          m.next_pin_oe[i]  = !m.pwm_tristate;
        end
        SPD_SRC_LATCH: begin
          m.next_pin_out[i] = m.out_latch[i];
          m.next_pin_oe[i]  = 1'b1;
        end
        SPD_SRC_NONE: begin
          m.next_pin_out[i] = 1'b0;
          m.next_pin_oe[i]  = 1'b0;
        end
      endcase
      // pull-up only on an undriven pin set as input
      m.next_pin_pullup[i] = m.pullup_req && m.direction[i] && !m.next_pin_oe[i];
    end
    // pins absent on the small package stay quiet
    m.next_pin_out    = m.next_pin_out & m.width_mask;
    m.next_pin_oe     = m.next_pin_oe & m.width_mask;
    m.next_pin_pullup = m.next_pin_pullup & m.width_mask;
  end

endmodule

// File: spd_port.sv
// Purpose: shared bidirectional port d with axi4-lite registers
// Assumes: pin, bus and peripheral inputs synchronous to aclk
// Notes:   package size strap is caught on the first edge after reset release
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "spd_params.svh"

// Contract
// - port is 3 bits on small packages, 8 bits on the large one
// - direction bit 1 makes the pin an input, driver off
// - direction bit 0 drives the pin from its output latch bit
// - latch register reads return latch values; writes update the latch
// - pin level register reads return the live pin levels
// - any reset makes every pin a digital input
// - large package: port functions only while bus-disable bit 7 is set
// - memory interface enabled: pins carry low address/data byte, direction overridden
// - one shared pull-up enable, bit 7 of port a latch, covers all pins
// - pull-up is forced off on any pin configured as output
// - every reset clears the shared pull-up enable
// - large package: parallel mode bit 4 makes an 8-bit slave port
// - parallel port beats other pin functions; memory interface beats it
// - parallel mode: read data from latch, write data from pin, direction ignored
// - routed pwm output overrides port data and may tri-state on shutdown
module spd_port
  import spd_pkg::*;
(
  input  wire logic        aclk,            // system clock
  input  wire logic        aresetn,         // synchronous reset, active low
  input  wire logic        large_package,   // strap: 1 = 8-pin port variant
  input  wire logic [7:0]  pin_in,          // pin levels
  output logic      [7:0]  pin_out,         // pin drive value
  output logic      [7:0]  pin_oe,          // pin drive enable, 1 = driving
  output logic      [7:0]  pin_pullup,      // weak pull-up enable per pin
  input  wire logic        emi_drive,       // memory bus output phase
  input  wire logic [7:0]  emi_addr_data,   // memory bus low byte out
  output logic      [7:0]  emi_data_in,     // memory bus low byte in
  output logic             emi_active,      // memory bus owns the pins
  input  wire logic        psp_read,        // parallel host reading
  output logic      [7:0]  psp_write_data,  // parallel host write byte
  output logic             psp_active,      // parallel slave port owns the pins
  input  wire logic        pwm_route,       // pwm channel b routed to pin 0
  input  wire logic        pwm_level,       // pwm channel b level
  input  wire logic        pwm_tristate,    // pwm shutdown tri-state
  input  wire logic [7:0]  s_axi_awaddr,    // write address
  input  wire logic        s_axi_awvalid,   // write address valid
  output logic             s_axi_awready,   // write address ready
  input  wire logic [31:0] s_axi_wdata,     // write data
  input  wire logic [3:0]  s_axi_wstrb,     // write strobes
  input  wire logic        s_axi_wvalid,    // write data valid
  output logic             s_axi_wready,    // write data ready
  output logic      [1:0]  s_axi_bresp,     // write response
  output logic             s_axi_bvalid,    // write response valid
  input  wire logic        s_axi_bready,    // write response ready
  input  wire logic [7:0]  s_axi_araddr,    // read address
  input  wire logic        s_axi_arvalid,   // read address valid
  output logic             s_axi_arready,   // read address ready
  output logic      [31:0] s_axi_rdata,     // read data
  output logic      [1:0]  s_axi_rresp,     // read response
  output logic             s_axi_rvalid,    // read data valid
  input  wire logic        s_axi_rready     // read data ready
);

  // ****************************************
  // state
  // ****************************************
  spd_byte_t   direction;
  spd_byte_t   out_latch;
  spd_byte_t   mem_ctrl;
  spd_byte_t   par_ctrl;
  spd_byte_t   porta_latch;
  logic        is_large;
  logic        strap_taken;
  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  spd_byte_t   width_mask;
  logic        next_emi_active;
  logic        next_psp_active;
  logic        do_write;

  spd_mux_if mux_bus ();

  function automatic logic spd_mapped(input logic [7:0] a);
    spd_mapped = (a == `SPD_OFF_PIN_LEVELS) || (a == `SPD_OFF_DIRECTION) ||
                 (a == `SPD_OFF_OUT_LATCH) || (a == `SPD_OFF_MEM_CTRL) ||
                 (a == `SPD_OFF_PAR_CTRL) || (a == `SPD_OFF_PORTA_LATCH) ||
                 (a == `SPD_OFF_STATUS);
  endfunction

  // every writable register sits in byte lane 0; upper lanes are dropped
  function automatic logic spd_wr_hit(input logic [7:0] off);
    spd_wr_hit = do_write && w_strb[0] && (aw_addr == off);
  endfunction

  // ****************************************
  // package size strap
  // ****************************************
  // caught by a clocked process after release, never loaded by reset itself
  // a strap that moves later is ignored until the next reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_taken <= 1'b0;
      is_large    <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      is_large    <= large_package;
    end
  end

  assign width_mask = is_large ? `SPD_MASK_LARGE : `SPD_MASK_SMALL;

  // bus and parallel port exist only on the large package
  assign next_emi_active = is_large && !mem_ctrl[`SPD_BIT_EXT_BUS_DIS];
  assign next_psp_active = is_large && mem_ctrl[`SPD_BIT_EXT_BUS_DIS] &&
                           par_ctrl[`SPD_BIT_PAR_MODE];

  // ****************************************
  // selector hookup
  // ****************************************
  assign mux_bus.direction     = direction;
  assign mux_bus.out_latch     = out_latch;
  assign mux_bus.width_mask    = width_mask;
  assign mux_bus.emi_active    = next_emi_active;
  assign mux_bus.emi_drive     = emi_drive;
  assign mux_bus.emi_addr_data = emi_addr_data;
  assign mux_bus.psp_active    = next_psp_active;
  assign mux_bus.psp_read      = psp_read;
  assign mux_bus.pwm_route     = pwm_route;
  assign mux_bus.pwm_level     = pwm_level;
  assign mux_bus.pwm_tristate  = pwm_tristate;
  assign mux_bus.pullup_req    = porta_latch[`SPD_BIT_PULLUP_EN];

  spd_pin_mux u_pin_mux (
    .m (mux_bus.sel)
  );

  // ****************************************
  // registered pin side
  // ****************************************
  // one register stage: every pin change lands one edge after its cause
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out    <= 8'h00;
      pin_oe     <= 8'h00;
      pin_pullup <= 8'h00;
      emi_active <= 1'b0;
      psp_active <= 1'b0;
    end else begin
      pin_out    <= mux_bus.next_pin_out;
      pin_oe     <= mux_bus.next_pin_oe;
      pin_pullup <= mux_bus.next_pin_pullup;
      emi_active <= next_emi_active;
      psp_active <= next_psp_active;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      emi_data_in    <= 8'h00;
      psp_write_data <= 8'h00;
    end else begin
      emi_data_in    <= pin_in & width_mask;
      psp_write_data <= pin_in & width_mask;
    end
  end

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  // address and data park separately, in either order, until both are in
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      // low on the taking edge so a held valid is never taken twice
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SPD_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= spd_mapped(aw_addr) ? `SPD_RESP_OKAY : `SPD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  // writing the pin level register lands in the latch, as on a real port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_latch <= `SPD_RST_OUT_LATCH;
    end else if (spd_wr_hit(`SPD_OFF_OUT_LATCH) || spd_wr_hit(`SPD_OFF_PIN_LEVELS)) begin
      out_latch <= w_data[7:0] & width_mask;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      direction <= `SPD_RST_DIRECTION;
    end else if (spd_wr_hit(`SPD_OFF_DIRECTION)) begin
      direction <= w_data[7:0] | ~width_mask; // absent pins stay inputs
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // bus starts disabled so the pins come up as plain inputs
      mem_ctrl <= `SPD_RST_MEM_CTRL;
    end else if (spd_wr_hit(`SPD_OFF_MEM_CTRL)) begin
      mem_ctrl <= w_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      par_ctrl <= `SPD_RST_PAR_CTRL;
    end else if (spd_wr_hit(`SPD_OFF_PAR_CTRL)) begin
      par_ctrl <= w_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      porta_latch <= `SPD_RST_PORTA_LATCH;
    end else if (spd_wr_hit(`SPD_OFF_PORTA_LATCH)) begin
      porta_latch <= w_data[7:0];
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SPD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= spd_mapped(s_axi_araddr) ? `SPD_RESP_OKAY : `SPD_RESP_SLVERR;
      // status shows the drive enables as registered, one edge behind the selector
      unique case (s_axi_araddr)
        `SPD_OFF_PIN_LEVELS:  s_axi_rdata <= {24'h00_0000, pin_in & width_mask};
        `SPD_OFF_DIRECTION:   s_axi_rdata <= {24'h00_0000, direction};
        `SPD_OFF_OUT_LATCH:   s_axi_rdata <= {24'h00_0000, out_latch};
        `SPD_OFF_MEM_CTRL:    s_axi_rdata <= {24'h00_0000, mem_ctrl};
        `SPD_OFF_PAR_CTRL:    s_axi_rdata <= {24'h00_0000, par_ctrl};
        `SPD_OFF_PORTA_LATCH: s_axi_rdata <= {24'h00_0000, porta_latch};
        `SPD_OFF_STATUS:      s_axi_rdata <= {23'h0, is_large, pin_oe};
        default:              s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// File: spd_port_sva.sv
// Purpose: pin-side checks for port d
// Assumes: strap held steady while out of reset
// Notes:   registered pins lag their cause by one edge
`timescale 1ns/10ps
module spd_port_sva (
  input wire logic       aclk,           // clock
  input wire logic       aresetn,        // reset
  input wire logic       large_package,  // strap
  input wire logic [7:0] pin_in,         // pin levels
  input wire logic [7:0] pin_out,        // drive value
  input wire logic [7:0] pin_oe,         // drive enable
  input wire logic [7:0] pin_pullup,     // pull-ups
  input wire logic       emi_drive,      // bus out phase
  input wire logic [7:0] emi_addr_data,  // bus byte
  input wire logic       emi_active,     // bus owns pins
  input wire logic       psp_read,       // host read
  input wire logic [7:0] psp_write_data, // host byte
  input wire logic       psp_active,     // slave port on
  input wire logic       pwm_route,      // pwm routed
  input wire logic       pwm_level,      // pwm level
  input wire logic       pwm_tristate    // pwm shutdown
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_reset_off;
    disable iff (1'b0) !aresetn |=> pin_oe == 8'h00 && pin_pullup == 8'h00;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("pins not off after reset");
  property p_pullup_out;
    (pin_pullup & pin_oe) == 8'h00;
  endproperty
  a_pullup_out: assert property (p_pullup_out) else $error("pull-up on a driven pin");
  property p_small;
    !large_package |-> pin_oe[7:3] == 5'h00 && pin_pullup[7:3] == 5'h00;
  endproperty
  a_small: assert property (p_small) else $error("upper pins used on small port");
  // two active cycles so the flag and the pin register agree
  property p_emi;
    emi_active [*2] |-> pin_oe == {8{$past(emi_drive)}} && pin_out == $past(emi_addr_data);
  endproperty
  a_emi: assert property (p_emi) else $error("memory bus not on pins");
  property p_psp_drive;
    psp_active [*2] |-> pin_oe == {8{$past(psp_read)}};
  endproperty
  a_psp_drive: assert property (p_psp_drive) else $error("slave port drive wrong");
  property p_psp_data;
    psp_active |=> psp_write_data == $past(pin_in);
  endproperty
  a_psp_data: assert property (p_psp_data) else $error("slave port byte wrong");
  property p_emi_wins;
    !(emi_active && psp_active);
  endproperty
  a_emi_wins: assert property (p_emi_wins) else $error("bus and slave port both own pins");
  property p_pwm;
    (!emi_active && !psp_active) [*2] ##0 $past(pwm_route) |->
      pin_oe[0] == !$past(pwm_tristate) && (!pin_oe[0] || pin_out[0] == $past(pwm_level));
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm not on pin 0");
  c_emi: cover property (emi_active && emi_drive);
  c_psp: cover property (psp_active && psp_read);
  c_pwm: cover property (pwm_route && pwm_tristate);
endmodule

bind spd_port spd_port_sva u_sva (
  .aclk(aclk), .aresetn(aresetn), .large_package(large_package), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .emi_drive(emi_drive),
  .emi_addr_data(emi_addr_data), .emi_active(emi_active), .psp_read(psp_read),
  .psp_write_data(psp_write_data), .psp_active(psp_active), .pwm_route(pwm_route),
  .pwm_level(pwm_level), .pwm_tristate(pwm_tristate));

// File: spd_pin_model.sv
// Purpose: external pins of port d
// Assumes: an outside source drives where ext_oe is set
// Notes:   a floating pin toggles every cycle, never holds
`timescale 1ns/10ps
module spd_pin_model (
  input wire logic       aclk,       // clock
  input wire logic [7:0] pin_out,    // device drive value
  input wire logic [7:0] pin_oe,     // device drive enable
  input wire logic [7:0] pin_pullup, // device pull-ups
  input wire logic [7:0] ext_val,    // outside level
  input wire logic [7:0] ext_oe,     // outside drives
  output logic     [7:0] pin_in      // resolved level
);
  logic [7:0] noise = 8'h55;
  always @(posedge aclk) noise <= ~noise;
  // device first, then outside source, then pull-up, else noise
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
                | (~pin_oe & ~ext_oe & (pin_pullup | noise));
endmodule

// File: spd_port_test.sv
// Purpose: self-checking bench for port d
// Assumes: axi4-lite master, ready signals held high
// Notes:   small package run comes last, after a second reset
`timescale 1ns/10ps
`include "spd_params.svh"
module spd_port_test;
  import spd_pkg::*;
  logic aclk = 0, aresetn = 0, large_package = 1;
  logic emi_drive = 0, psp_read = 0, pwm_route = 0, pwm_level = 0, pwm_tristate = 0;
  logic [7:0] emi_addr_data = 8'h00, ext_val = 8'h00, ext_oe = 8'h00;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, emi_data_in, psp_write_data;
  logic emi_active, psp_active;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_bready = 1, s_axi_rready = 1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] dat;
  int errors = 0, checks = 0;

  always #4 aclk = ~aclk;
  spd_port u_dut (.aclk(aclk), .aresetn(aresetn), .large_package(large_package), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .emi_drive(emi_drive),
    .emi_addr_data(emi_addr_data), .emi_data_in(emi_data_in), .emi_active(emi_active),
    .psp_read(psp_read), .psp_write_data(psp_write_data), .psp_active(psp_active),
    .pwm_route(pwm_route), .pwm_level(pwm_level), .pwm_tristate(pwm_tristate),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  spd_pin_model u_pins (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .ext_val(ext_val), .ext_oe(ext_oe), .pin_in(pin_in));

  // ****************************************
  // bus and compare helpers
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    dat = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(nm, dat, exp);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rc("dir", 8'h04, 32'hff);
    rc("latch", 8'h08, 32'h00);
    rc("memctl", 8'h0c, 32'h80);
    rc("pullen", 8'h14, 32'h00);
    rc("status", 8'h18, 32'h100);
    chk("rresp", rsp, `SPD_RESP_OKAY);
    chk("oe", pin_oe, 32'h00);
  endtask
  task automatic t_latch;
    wr(8'h08, 32'h5a);
    chk("bresp", rsp, `SPD_RESP_OKAY);
    wr(8'h04, 32'h0f);
    ext_oe <= 8'h0f;
    ext_val <= 8'h03;
    cyc(2);
    chk("oe", pin_oe, 32'hf0);
    chk("out", pin_out & 8'hf0, 32'h50);
    rc("pins", 8'h00, 32'h53);
    rc("latch", 8'h08, 32'h5a);
    wr(8'h00, 32'ha5);
    rc("latch", 8'h08, 32'ha5);
    ext_oe <= 8'h00;
  endtask
  task automatic t_pullup;
    wr(8'h14, 32'h80);
    cyc(2);
    chk("pullup", pin_pullup, 32'h0f);
    wr(8'h04, 32'hff);
    cyc(2);
    chk("pullup", pin_pullup, 32'hff);
    chk("oe", pin_oe, 32'h00);
  endtask
  task automatic t_emi;
    emi_drive <= 1'b1;
    emi_addr_data <= 8'h3c;
    wr(8'h0c, 32'h00);
    wr(8'h10, 32'h10);
    cyc(3);
    chk("emi", emi_active, 32'h1);
    chk("oe", pin_oe, 32'hff);
    chk("out", pin_out, 32'h3c);
    chk("psp", psp_active, 32'h0);
    emi_drive <= 1'b0;
    ext_oe <= 8'hff;
    ext_val <= 8'h96;
    cyc(3);
    chk("oe", pin_oe, 32'h00);
    chk("emidata", emi_data_in, 32'h96);
    ext_oe <= 8'h00;
  endtask
  task automatic t_psp;
    wr(8'h0c, 32'h80);
    wr(8'h04, 32'h00);
    psp_read <= 1'b1;
    pwm_route <= 1'b1;
    cyc(3);
    chk("psp", psp_active, 32'h1);
    chk("out", pin_out, 32'ha5);
    chk("oe", pin_oe, 32'hff);
    psp_read <= 1'b0;
    ext_oe <= 8'hff;
    ext_val <= 8'hc3;
    cyc(3);
    chk("oe", pin_oe, 32'h00);
    chk("hostbyte", psp_write_data, 32'hc3);
    ext_oe <= 8'h00;
  endtask
  task automatic t_pwm;
    wr(8'h10, 32'h00);
    cyc(3);
    chk("out0", pin_out[0], 32'h0);
    chk("oe", pin_oe, 32'hff);
    pwm_tristate <= 1'b1;
    cyc(2);
    chk("oe", pin_oe, 32'hfe);
    pwm_route <= 1'b0;
    cyc(2);
    chk("out0", pin_out[0], 32'h1);
  endtask
  task automatic t_bus;
    rc("unmapped", 8'h40, 32'h0);
    chk("rresp", rsp, `SPD_RESP_SLVERR);
    wr(8'h44, 32'hff);
    chk("bresp", rsp, `SPD_RESP_SLVERR);
  endtask
  task automatic t_small;
    aresetn <= 1'b0;
    large_package <= 1'b0;
    cyc(8);
    aresetn <= 1'b1;
    cyc(2);
    rc("status", 8'h18, 32'h0);
    rc("pullen", 8'h14, 32'h00);
    wr(8'h04, 32'h00);
    wr(8'h08, 32'hff);
    wr(8'h0c, 32'h00);
    cyc(3);
    chk("oe", pin_oe, 32'h07);
    chk("emi", emi_active, 32'h0);
    rc("dir", 8'h04, 32'hf8);
  endtask

  initial begin
    cyc(8);
    aresetn <= 1'b1;
    cyc(2);
    t_reset();
    t_latch();
    t_pullup();
    t_emi();
    t_psp();
    t_pwm();
    t_bus();
    t_small();
    give_verdict();
  end
  initial begin
    #400000;
    errors++;
    give_verdict();
  end
endmodule
